// ### ams_consts.svh
// Constants for the converter channel/reference staging block: offsets, fields, resets, counts.
// Included by the selection buffer, sequencer, top and bench files; holds definitions only.
// Behaviour
// R1 - Processor-accessible temporary channel/reference register
// R2 - Idle: active selection follows temporary register
// R3 - Conversion start freezes the active selection
// R4 - Copying resumes in final conversion cycle
// R5 - Start begins at next clock edge
// R6 - Software waits one cycle after start
// R7 - Auto-trigger: clear enable before changing
// R8 - Auto-trigger: change one cycle after trigger
// R9 - Auto-trigger: change before trigger flag clears
// R10 - Safe-window write applies to next conversion
// R11 - Single mode: select channel before start
// R12 - Free-run restart keeps previous channel
// R13 - Reference: supply, 1.1V bandgap, external pin
// R14 - Over-reference input gives full-scale code
// R15 - Conversion 13 cycles, sample at 1.5
// R16 - Copy every edge while unlocked; reset value
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH
`define AMS_OFF_CHREF 8'h00
`define AMS_OFF_CTRL 8'h04
`define AMS_OFF_ACTIVE 8'h08
`define AMS_OFF_RESULT 8'h0C
`define AMS_OFF_IRQ_ST 8'h10
`define AMS_OFF_IRQ_CLR 8'h14
`define AMS_OFF_IRQ_EN 8'h18
`define AMS_CTRL_EN 7
`define AMS_CTRL_START 6
`define AMS_CTRL_AUTO 5
`define AMS_CTRL_DONE 4
`define AMS_CTRL_FREE 0
`define AMS_IRQ_DONE 0
`define AMS_IRQ_START 1
`define AMS_CHREF_RST 8'h00
`define AMS_CONV_CYCLES 13
`define AMS_SH_CYCLE 1
`define AMS_FULL_SCALE 10'h3FF
`endif

// ### ams_core_model.sv
// Behavioural converter core for the staging block bench.
// Assumes sample_hold is a one-cycle pulse in the core_clk domain.
`timescale 1ns/1ns
module ams_core_model (
  // Clock
  input wire logic core_clk,
  // Applied selection
  input wire logic [3:0] mux_chan,
  input wire logic [1:0] ref_src,
  input wire logic sample_hold,
  // Conversion answer
  output logic [9:0] core_result,
  output logic core_over_ref
);
  initial begin
    core_result = 10'h000;
    core_over_ref = 1'b0;
  end
  // Code echoes reference and channel so a late switch shows in the result
  always @(posedge core_clk) begin
    if (sample_hold === 1'b1) begin
      core_result <= {ref_src, 4'h0, mux_chan};
      core_over_ref <= (mux_chan == 4'hF);
    end
  end
endmodule : ams_core_model

// ### ams_link_if.sv
// Link between register front end, conversion sequencer and selection buffer.
// All signals live in the single core_clk domain.
`timescale 1ns/1ns
interface ams_link_if;
  import ams_pkg::*;
  logic go;
  logic restart;
  logic busy;
  logic last;
  logic lock;
  logic sh;
  ams_sel_s temp_sel;
  ams_sel_s active_sel;
  modport seq (input go, input restart, output busy, output last, output lock, output sh);
  modport sbuf (input lock, input temp_sel, output active_sel);
  modport top (output go, output restart, output temp_sel, input busy, input last, input lock, input sh,
               input active_sel);
endinterface : ams_link_if

// ### ams_pkg.sv
// Types shared by the staging block modules.
// Assumes the constants header is compiled alongside.
package ams_pkg;
  typedef enum logic [1:0] {
    AMS_REF_EXT_PIN = 2'b00,
    AMS_REF_SUPPLY = 2'b01,
    AMS_REF_RSVD = 2'b10,
    AMS_REF_BANDGAP = 2'b11
  } ams_ref_e;
  typedef struct packed {
    logic [1:0] reference_source_field;
    logic [3:0] input_channel_select_bits;
  } ams_sel_s;
  typedef enum logic {
    AMS_IDLE = 1'b0,
    AMS_CONV = 1'b1
  } ams_state_e;
  typedef logic [3:0] ams_cnt_t;
  function automatic ams_sel_s ams_sel_from_byte(input logic [7:0] b);
    ams_sel_s s;
    s.reference_source_field = b[7:6];
    s.input_channel_select_bits = b[3:0];
    return s;
  endfunction : ams_sel_from_byte
  function automatic logic [7:0] ams_sel_to_byte(input ams_sel_s s);
    return {s.reference_source_field, 2'b00, s.input_channel_select_bits};
  endfunction : ams_sel_to_byte
endpackage : ams_pkg

// ### ams_selbuf.sv
// Active selection register fed from the temporary register while not locked.
// Assumes lock comes from the sequencer in the same clock domain.
`timescale 1ns/1ns
`include "ams_consts.svh"
module ams_selbuf import ams_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Link
  ams_link_if.sbuf link
);
  ams_sel_s active_q, active_d;

  always_comb begin
    active_d = link.lock ? active_q : link.temp_sel; // [R2] [R3] [R10] [R16]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_q <= ams_sel_from_byte(`AMS_CHREF_RST); // [R16]
    end else if (clk_en) begin
      active_q <= active_d;
    end
  end

  assign link.active_sel = active_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  chk_lock_hold: assert property (link.lock |=> active_q == $past(active_q)) // [R3]
    else $error("active selection moved while locked");
  chk_copy_open: assert property (!link.lock |=> active_q == $past(link.temp_sel)) // [R2]
    else $error("active selection not copied while unlocked");
endmodule : ams_selbuf

// ### ams_seq.sv
// Conversion sequencer: counts converter cycles, marks sample point and final cycle.
// Assumes go is only raised by the front end while idle or in the final cycle.
`timescale 1ns/1ns
`include "ams_consts.svh"
module ams_seq import ams_pkg::*; #(
  parameter int CONV_CYCLES = `AMS_CONV_CYCLES,
  parameter int SH_CYCLE = `AMS_SH_CYCLE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Link
  ams_link_if.seq link
);
  localparam ams_cnt_t LAST = ams_cnt_t'(CONV_CYCLES - 1);
  localparam ams_cnt_t SH = ams_cnt_t'(SH_CYCLE);
  ams_state_e state_q, state_d;
  ams_cnt_t cnt_q, cnt_d;
  logic sh_q, sh_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      AMS_IDLE: if (link.go) begin // [R5]
        state_d = AMS_CONV;
        cnt_d = '0;
      end
      AMS_CONV: if (cnt_q == LAST) begin // [R15]
        if (link.restart) begin // [R12]
          cnt_d = '0;
        end else begin
          state_d = AMS_IDLE;
        end
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    endcase
    // Sample-and-hold sits between edges 1 and 2; flagged on the cycle after edge 1
    sh_d = (state_d == AMS_CONV) && (cnt_d == SH); // [R15]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= AMS_IDLE;
      cnt_q <= '0;
      sh_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  assign link.busy = (state_q == AMS_CONV);
  assign link.last = (state_q == AMS_CONV) && (cnt_q == LAST);
  assign link.lock = (state_q == AMS_CONV) && (cnt_q != LAST); // [R3] [R4]
  assign link.sh = sh_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  chk_conv_length: assert property (link.go && !link.busy |-> ##13 link.last) // [R15]
    else $error("conversion did not end after 13 cycles");
  chk_sample_point: assert property (link.go && !link.busy |-> ##2 link.sh) // [R15]
    else $error("sample point not at cycle 1");
  chk_freerun_restart: assert property (link.last && link.restart |=> link.busy && cnt_q == '0) // [R12]
    else $error("free-run restart missing");
  cov_restart: cover property (link.last && link.restart);
endmodule : ams_seq

// ### ams_top.sv
// Top of the channel/reference staging block: APB registers, start/trigger control,
// result capture and interrupt. Instantiates the sequencer and selection buffer.
// Assumes APB and converter-core inputs are synchronous to core_clk.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ns
`include "ams_consts.svh"
module ams_top import ams_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int RES_W = 10
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic trig_in,
  input wire logic [RES_W-1:0] core_result,
  input wire logic core_over_ref,
  output logic [3:0] mux_chan,
  output logic [1:0] ref_src,
  output logic sample_hold,
  output logic conv_busy,
  // Interrupt
  output logic irq
);
  ams_link_if link ();

  ams_seq #(
    .CONV_CYCLES(`AMS_CONV_CYCLES),
    .SH_CYCLE(`AMS_SH_CYCLE)
  ) u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .link(link.seq)
  );

  ams_selbuf u_selbuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .link(link.sbuf)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, `AMS_OFF_CHREF) || hit(a, `AMS_OFF_CTRL) || hit(a, `AMS_OFF_ACTIVE) ||
           hit(a, `AMS_OFF_RESULT) || hit(a, `AMS_OFF_IRQ_ST) || hit(a, `AMS_OFF_IRQ_CLR) ||
           hit(a, `AMS_OFF_IRQ_EN);
  endfunction : mapped

  // Register state
  ams_sel_s temp_q, temp_d;
  logic en_q, en_d;
  logic auto_q, auto_d;
  logic free_q, free_d;
  logic start_q, start_d;
  logic done_q, done_d;
  logic trig_q, trig_d;
  logic [RES_W-1:0] result_q, result_d;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_en_q, irq_en_d;
  logic irq_q, irq_d;
  // Bus answer state
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // Bus decode
  logic acc;
  logic wr;
  logic trig_rise;
  logic go;
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;

  always_comb begin
    acc = psel && penable && pready_q;
    wr = acc && pwrite && mapped(paddr);
    trig_rise = trig_in && !trig_q;
    // Start bit or a trigger edge only counts while idle; triggers mid-conversion are dropped
    go = en_q && !link.busy && (start_q || (auto_q && trig_rise)); // [R5]
    irq_ev = 2'b00;
    irq_ev[`AMS_IRQ_DONE] = link.last;
    irq_ev[`AMS_IRQ_START] = go;
    irq_clr = (wr && hit(paddr, `AMS_OFF_IRQ_CLR)) ? pwdata[1:0] : 2'b00;
  end

  assign link.go = go;
  assign link.restart = en_q && auto_q && free_q; // [R12]
  assign link.temp_sel = temp_q;

  // Register next values
  always_comb begin
    temp_d = temp_q;
    en_d = en_q;
    auto_d = auto_q;
    free_d = free_q;
    irq_en_d = irq_en_q;
    if (wr && hit(paddr, `AMS_OFF_CHREF)) begin
      temp_d = ams_sel_from_byte(pwdata[7:0]); // [R1] [R13]
    end
    if (wr && hit(paddr, `AMS_OFF_CTRL)) begin
      en_d = pwdata[`AMS_CTRL_EN];
      auto_d = pwdata[`AMS_CTRL_AUTO];
      free_d = pwdata[`AMS_CTRL_FREE];
    end
    if (wr && hit(paddr, `AMS_OFF_IRQ_EN)) begin
      irq_en_d = pwdata[1:0];
    end
    // Start request is taken by the sequencer one edge after the write lands
    start_d = (start_q && !go) ||
              (wr && hit(paddr, `AMS_OFF_CTRL) && pwdata[`AMS_CTRL_START] && pwdata[`AMS_CTRL_EN]); // [R5]
    // Set wins over a write-one clear in the same cycle
    done_d = (done_q && !(wr && hit(paddr, `AMS_OFF_CTRL) && pwdata[`AMS_CTRL_DONE])) || link.last;
    irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
    irq_d = |(irq_st_d & irq_en_d);
    trig_d = trig_in;
    result_d = result_q;
    if (link.last) begin
      result_d = core_over_ref ? RES_W'(`AMS_FULL_SCALE) : core_result; // [R14]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      temp_q <= ams_sel_from_byte(`AMS_CHREF_RST);
      en_q <= 1'b0;
      auto_q <= 1'b0;
      free_q <= 1'b0;
      start_q <= 1'b0;
      done_q <= 1'b0;
      trig_q <= 1'b0;
      result_q <= '0;
      irq_st_q <= 2'b00;
      irq_en_q <= 2'b00;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      temp_q <= temp_d;
      en_q <= en_d;
      auto_q <= auto_d;
      free_q <= free_d;
      start_q <= start_d;
      done_q <= done_d;
      trig_q <= trig_d;
      result_q <= result_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // Bus answer: one wait state, so read data is built from settled registers
  always_comb begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped(paddr);
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      if (hit(paddr, `AMS_OFF_CHREF)) begin
        prdata_d[7:0] = ams_sel_to_byte(temp_q); // [R1]
      end
      if (hit(paddr, `AMS_OFF_CTRL)) begin
        prdata_d[`AMS_CTRL_EN] = en_q;
        prdata_d[`AMS_CTRL_START] = start_q || link.busy;
        prdata_d[`AMS_CTRL_AUTO] = auto_q;
        prdata_d[`AMS_CTRL_DONE] = done_q;
        prdata_d[`AMS_CTRL_FREE] = free_q;
      end
      if (hit(paddr, `AMS_OFF_ACTIVE)) begin
        prdata_d[7:0] = ams_sel_to_byte(link.active_sel);
      end
      if (hit(paddr, `AMS_OFF_RESULT)) begin
        prdata_d[RES_W-1:0] = result_q;
      end
      if (hit(paddr, `AMS_OFF_IRQ_ST)) begin
        prdata_d[1:0] = irq_st_q;
      end
      if (hit(paddr, `AMS_OFF_IRQ_EN)) begin
        prdata_d[1:0] = irq_en_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mux_chan = link.active_sel.input_channel_select_bits;
  assign ref_src = link.active_sel.reference_source_field; // [R13]
  assign sample_hold = link.sh;
  assign conv_busy = link.busy;
  assign irq = irq_q;

  // Assertion helper: a busy-cycle count kept apart from the sequencer's own counter
  // Lock window and final cycle are then checked against an independent reference
  localparam ams_cnt_t CONV_LAST = ams_cnt_t'(`AMS_CONV_CYCLES - 1);
  ams_cnt_t busy_len_q, busy_len_d;

  always_comb begin
    busy_len_d = '0;
    if (link.busy && (busy_len_q != CONV_LAST)) begin // [R15]
      busy_len_d = busy_len_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_len_q <= '0;
    end else if (clk_en) begin
      busy_len_q <= busy_len_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  chk_temp_write: assert property (wr && hit(paddr, `AMS_OFF_CHREF) // [R1]
    |=> ams_sel_to_byte(temp_q) == ($past(pwdata[7:0]) & 8'hCF))
    else $error("temporary selection not stored");
  chk_start_edge: assert property (start_q && en_q && !link.busy |=> link.busy && !start_q) // [R5]
    else $error("conversion did not start on next edge");
  chk_next_conv: assert property (go && !link.busy |=> ##1 link.active_sel == $past(temp_q, 2)) // [R10]
    else $error("conversion did not use latest selection");
  chk_full_scale: assert property (link.last && core_over_ref |=> result_q == `AMS_FULL_SCALE) // [R14]
    else $error("over-reference result not full scale");
  chk_done_flag: assert property (link.last |=> done_q && irq_st_q[`AMS_IRQ_DONE])
    else $error("done flag not set at final cycle");
  chk_irq_level: assert property (irq_q == |(irq_st_q & irq_en_q))
    else $error("interrupt level disagrees with status");
  chk_apb_answer: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("bus answer missing");

  // Bus answer and register writes
  chk_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("bus answer stood longer than one cycle");
  chk_slverr_map: assert property (pready_q
    |-> pslverr_q == !mapped(paddr))
    else $error("error answer does not match address map");
  chk_unmapped_wr: assert property (psel && penable && pready_q && pwrite && !mapped(paddr)
    |=> $stable(temp_q) && $stable(en_q) && $stable(irq_en_q))
    else $error("write to unmapped address changed a register");
  chk_ctrl_write: assert property (wr && hit(paddr, `AMS_OFF_CTRL)
    |=> en_q == $past(pwdata[`AMS_CTRL_EN]) && auto_q == $past(pwdata[`AMS_CTRL_AUTO]) &&
        free_q == $past(pwdata[`AMS_CTRL_FREE]))
    else $error("control fields not stored");
  chk_irq_en_write: assert property (wr && hit(paddr, `AMS_OFF_IRQ_EN)
    |=> irq_en_q == $past(pwdata[1:0]))
    else $error("interrupt enable not stored");

  // Start, trigger, flags and result
  chk_start_needs_en: assert property (wr && hit(paddr, `AMS_OFF_CTRL) && pwdata[`AMS_CTRL_START] && // [R5]
    !pwdata[`AMS_CTRL_EN] && !start_q |=> !start_q)
    else $error("start accepted without enable");
  chk_trig_start: assert property (en_q && auto_q && trig_rise && !link.busy
    |=> link.busy)
    else $error("trigger edge did not start a conversion");
  chk_start_event: assert property (go |=> irq_st_q[`AMS_IRQ_START])
    else $error("start event not flagged");
  chk_irq_clear: assert property (irq_clr[`AMS_IRQ_DONE] && !link.last
    |=> !irq_st_q[`AMS_IRQ_DONE])
    else $error("done status not cleared");
  chk_done_clear: assert property (wr && hit(paddr, `AMS_OFF_CTRL) && pwdata[`AMS_CTRL_DONE] && !link.last
    |=> !done_q)
    else $error("done flag not cleared");
  chk_result_hold: assert property (!link.last |=> $stable(result_q)) // [R15]
    else $error("result moved outside the final cycle");

  // Conversion timing against the independent count
  chk_busy_count: assert property (link.busy // [R15]
    |-> link.last == (busy_len_q == CONV_LAST))
    else $error("final cycle not at the thirteenth busy cycle");
  chk_lock_window: assert property (link.busy // [R3] [R4]
    |-> link.lock == (busy_len_q != CONV_LAST))
    else $error("lock window does not end at the final cycle");

  cov_single: cover property (start_q && !auto_q ##1 link.busy ##13 !link.busy);
  cov_trigger: cover property (auto_q && trig_rise && go);
  cov_write_locked: cover property (wr && hit(paddr, `AMS_OFF_CHREF) && link.lock);
  cov_trig_refused: cover property (link.busy && auto_q && trig_rise);
endmodule : ams_top

// ### ams_top_tb.sv
// Self-checking bench for the channel/reference staging block.
// Assumes the design files and the converter core model are compiled first.
`timescale 1ns/1ns
`include "ams_consts.svh"
module ams_top_tb;
  logic core_clk, rst_n, clk_en, psel, penable, pwrite, trig_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, rerr, core_over_ref, sample_hold, conv_busy, irq;
  logic [9:0] core_result;
  logic [3:0] mux_chan;
  logic [1:0] ref_src;
  int fails = 0;
  int num_checks = 0;
  int run = 0;
  int run_len = 0;
  int sh_at = 0;
  localparam logic [7:0] WR_V [5] = '{8'hC5, 8'h41, 8'h3A, 8'h8F, 8'h00};
  localparam logic [7:0] EXP_V [5] = '{8'hC5, 8'h41, 8'h0A, 8'h8F, 8'h00};

  ams_top uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .core_result(core_result), .core_over_ref(core_over_ref), .mux_chan(mux_chan),
    .ref_src(ref_src), .sample_hold(sample_hold), .conv_busy(conv_busy), .irq(irq));
  ams_core_model core (.core_clk(core_clk), .mux_chan(mux_chan), .ref_src(ref_src),
    .sample_hold(sample_hold), .core_result(core_result), .core_over_ref(core_over_ref));

  always #4 core_clk = ~core_clk;

  // Busy length and hold position, measured on pre-edge values
  always @(posedge core_clk) begin
    if (sample_hold === 1'b1) sh_at <= run;
    if (conv_busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      run_len <= run;
      run <= 0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      results();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  // sel 0 watches conv_busy, sel 1 watches irq
  task automatic wait_for(input logic sel, input logic val);
    int n;
    n = 0;
    while (((sel ? irq : conv_busy) !== val) && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      fails++;
      results();
    end
  endtask : wait_for

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trig_in = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(mux_chan, 4'h0);
    chk(ref_src, 2'h0);
    chk(irq, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `AMS_OFF_CHREF, WR_V[i]);
      apb(1'b0, `AMS_OFF_CHREF, 32'h0);
      chk(rdata, EXP_V[i]);
      apb(1'b0, `AMS_OFF_ACTIVE, 32'h0);
      chk(rdata, EXP_V[i]);
      chk(mux_chan, EXP_V[i][3:0]);
      chk(ref_src, EXP_V[i][7:6]);
    end
    $display("test table done");
    apb(1'b1, `AMS_OFF_ACTIVE, 32'hFF);
    apb(1'b0, `AMS_OFF_ACTIVE, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
    $display("test access done");
    // Single conversion with a selection write inside the lock window
    apb(1'b1, `AMS_OFF_CHREF, 32'h43);
    apb(1'b1, `AMS_OFF_IRQ_EN, 32'h1);
    apb(1'b1, `AMS_OFF_CTRL, 32'hC0);
    chk(conv_busy, 1'b0);
    wait_for(1'b0, 1'b1);
    apb(1'b1, `AMS_OFF_CHREF, 32'h0C);
    chk(mux_chan, 4'h3);
    chk(ref_src, 2'h1);
    apb(1'b0, `AMS_OFF_CTRL, 32'h0);
    chk(rdata, 32'hC0);
    wait_for(1'b0, 1'b0);
    chk(mux_chan, 4'hC);
    chk(ref_src, 2'h0);
    // The run counter hands over its length one edge after busy falls
    @(posedge core_clk);
    #1;
    chk(run_len, `AMS_CONV_CYCLES);
    chk(sh_at, `AMS_SH_CYCLE);
    apb(1'b0, `AMS_OFF_RESULT, 32'h0);
    chk(rdata, 32'h103);
    chk(irq, 1'b1);
    apb(1'b0, `AMS_OFF_IRQ_ST, 32'h0);
    chk(rdata, 32'h3);
    apb(1'b0, `AMS_OFF_CTRL, 32'h0);
    chk(rdata, 32'h90);
    apb(1'b1, `AMS_OFF_IRQ_EN, 32'h0);
    @(posedge core_clk);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, `AMS_OFF_IRQ_CLR, 32'h3);
    apb(1'b0, `AMS_OFF_IRQ_ST, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, `AMS_OFF_IRQ_EN, 32'h1);
    $display("test single done");
    // Free running: change after first result keeps old channel for one more
    apb(1'b1, `AMS_OFF_CHREF, 32'h4F);
    apb(1'b1, `AMS_OFF_CTRL, 32'hE1);
    wait_for(1'b1, 1'b1);
    apb(1'b1, `AMS_OFF_CHREF, 32'h45);
    chk(mux_chan, 4'hF);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `AMS_OFF_IRQ_CLR, 32'h3);
      wait_for(1'b1, 1'b0);
      wait_for(1'b1, 1'b1);
      apb(1'b0, `AMS_OFF_RESULT, 32'h0);
      chk(rdata, (k == 0) ? 32'h3FF : 32'h105);
    end
    apb(1'b1, `AMS_OFF_CTRL, 32'h0);
    wait_for(1'b0, 1'b0);
    apb(1'b1, `AMS_OFF_CHREF, 32'h46);
    $display("test free run done");
    // Trigger edge starts a conversion under auto-trigger; a frozen clock stretches it
    apb(1'b1, `AMS_OFF_CTRL, 32'hA0);
    @(posedge core_clk);
    trig_in <= 1'b1;
    wait_for(1'b0, 1'b1);
    chk(mux_chan, 4'h6);
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    trig_in <= 1'b0;
    apb(1'b1, `AMS_OFF_CHREF, 32'h07);
    chk(mux_chan, 4'h6);
    wait_for(1'b0, 1'b0);
    @(posedge core_clk);
    #1;
    chk(run_len, `AMS_CONV_CYCLES + 3);
    chk(mux_chan, 4'h7);
    @(posedge core_clk);
    trig_in <= 1'b1;
    wait_for(1'b0, 1'b1);
    chk(mux_chan, 4'h7);
    // A trigger edge inside a conversion is dropped
    @(posedge core_clk);
    trig_in <= 1'b0;
    @(posedge core_clk);
    trig_in <= 1'b1;
    wait_for(1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    trig_in <= 1'b0;
    #1;
    chk(conv_busy, 1'b0);
    $display("test trigger done");
    // Reset in mid-conversion returns outputs and registers to their reset values
    apb(1'b1, `AMS_OFF_CTRL, 32'hC0);
    wait_for(1'b0, 1'b1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(conv_busy, 1'b0);
    chk(mux_chan, 4'h0);
    chk(irq, 1'b0);
    apb(1'b0, `AMS_OFF_CHREF, 32'h0);
    chk(rdata, 32'h0);
    $display("test mid reset done");
    results();
  end
endmodule : ams_top_tb
